// ==== design/pfm_pin_router.sv ====
// Multi-purpose pin router with phone-ring and panel-switch supply control.
// Pads are split into input, output and output enable; the pad ring resolves them.
// Pad order in the packed pad vectors: 0 p14, 1 p15, 2 ring, 3 pof, 4 sup, 5 pan.
`timescale 1ns/1ps
module pfm_pin_router #(
    parameter bit EXTENDED = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // AXI4-Lite write
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [pfm_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // AXI4-Lite read
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [pfm_pkg::ADDR_W-1:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // Function sources
    input wire logic irq14_in,
    input wire logic irq15_in,
    input wire logic power_led_in,
    input wire logic watchdog_in,
    input wire logic ir_module_sel1_in,
    input wire logic ir_module_sel2_in,
    input wire logic [5:0] gpio_o_in,
    input wire logic [5:0] gpio_oe_in,
    input wire logic kbd_port_line16_in,
    input wire logic kbd_port_line16_oe_in,
    input wire logic main_power_ok_in,
    // Pads
    input wire logic [5:0] pad_in,
    output logic [5:0] pad_out,
    output logic [5:0] pad_oe_out,
    // Routed inputs and status
    output logic [5:0] gpio_i_out,
    output logic kbd_port_line16_out,
    output logic uartc_ring_out,
    output logic uartc_carrier_out,
    output logic supply_onoff_ctl_out,
    output logic clk_24m_sel_out,
    output logic irq_out
);
    import pfm_pkg::*;

    pfm_state_t s;
    pfm_state_t n;
    logic ring_fall;
    logic pan_fall;
    logic [1:0] d14;
    logic [1:0] d15;
    logic [1:0] dpof;

    // Four-way pad driver, returns {oe, out}
    function automatic logic [1:0] pad4(input logic [1:0] sel,
        input logic [1:0] c0, input logic [1:0] c1,
        input logic [1:0] c2, input logic [1:0] c3);
        case (sel)
            SEL_BASE: pad4 = c0;
            SEL_GPIO: pad4 = c1;
            SEL_ALT: pad4 = c2;
            default: pad4 = c3;
        endcase
    endfunction

    always_comb
    begin
        n = s;
        ring_fall = (s.ctl_b[F_RING+:2] == SEL_BASE) && s.ring_q && !pad_in[2];
        pan_fall = (s.ctl_b[F_PAN+:2] == SEL_BASE) && s.pan_q && !pad_in[5];
        n.ring_q = pad_in[2];
        n.pan_q = pad_in[5];

        // Write channel: address and data may arrive in either order
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            n.aw_seen = 1'b1;
            n.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            n.w_seen = 1'b1;
            n.wdata = s_axi_wdata_in[7:0];
            n.wlane0 = s_axi_wstrb_in[0];
        end
        if (s.bvalid && s_axi_bready_in)
        begin
            n.bvalid = 1'b0;
        end
        if (s.aw_seen && s.w_seen && !s.bvalid)
        begin
            n.aw_seen = 1'b0;
            n.w_seen = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (s.awaddr == ADDR_CTL_C)
            begin
                if (s.wlane0) n.ctl_c = s.wdata;
            end
            else if (s.awaddr == ADDR_CTL_B)
            begin
                if (s.wlane0) n.ctl_b = s.wdata;
            end
            else if (s.awaddr == ADDR_GCFG)
            begin
                if (s.wlane0) n.gcfg = s.wdata; // see R3
            end
            else if (s.awaddr == ADDR_CLR)
            begin
                if (s.wlane0) n.sts = s.sts & ~s.wdata[NEV-1:0];
            end
            else if (s.awaddr == ADDR_EN)
            begin
                if (s.wlane0) n.en = s.wdata[NEV-1:0];
            end
            else if (s.awaddr != ADDR_STS && s.awaddr != ADDR_PADS)
            begin
                n.bresp = RESP_SLVERR;
            end
        end

        // Read channel
        if (s.rvalid && s_axi_rready_in)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            if (s_axi_araddr_in == ADDR_CTL_C) n.rdata = {24'h0, s.ctl_c};
            else if (s_axi_araddr_in == ADDR_CTL_B) n.rdata = {24'h0, s.ctl_b};
            else if (s_axi_araddr_in == ADDR_GCFG) n.rdata = {24'h0, s.gcfg};
            else if (s_axi_araddr_in == ADDR_STS) n.rdata = {29'h0, s.sts};
            else if (s_axi_araddr_in == ADDR_EN) n.rdata = {29'h0, s.en};
            else if (s_axi_araddr_in == ADDR_PADS) n.rdata = {26'h0, pad_in};
            else if (s_axi_araddr_in == ADDR_CLR) n.rdata = 32'h0;
            else
            begin
                n.rdata = 32'h0;
                n.rresp = RESP_SLVERR;
            end
        end

        // Readies kept in flops, worked out from the next state
        n.aw_rdy = !n.aw_seen && !n.bvalid;
        n.w_rdy = !n.w_seen && !n.bvalid;
        n.ar_rdy = !n.rvalid;

        // Power control; events set after the clear so a set wins
        if (ring_fall)
        begin
            n.supply_on = 1'b1; // see R5
            n.sts[EV_RING] = 1'b1;
        end
        if (pan_fall && !main_power_ok_in)
        begin
            n.supply_on = 1'b1; // see R10
            n.sts[EV_ON] = 1'b1;
        end
        else if (pan_fall)
        begin
            n.supply_on = 1'b0; // see R11
            n.sts[EV_OFF] = 1'b1;
        end
        n.irq = |(n.sts & n.en);

        // Pin routing from the current fields
        d14 = pad4(s.ctl_c[F_P14+:2], {1'b1, irq14_in}, {gpio_oe_in[0], gpio_o_in[0]},
            {1'b1, power_led_in}, {EXTENDED, ir_module_sel1_in}); // see R1, R13
        d15 = pad4(s.ctl_c[F_P15+:2], {1'b1, irq15_in}, {gpio_oe_in[1], gpio_o_in[1]},
            {1'b1, watchdog_in}, {EXTENDED, ir_module_sel2_in}); // see R2
        dpof = pad4(s.ctl_b[F_POF+:2], {1'b1, n.irq}, {gpio_oe_in[3], gpio_o_in[3]},
            {kbd_port_line16_oe_in, kbd_port_line16_in}, 2'h0); // see R6
        {n.pad_e[0], n.pad_o[0]} = d14;
        {n.pad_e[1], n.pad_o[1]} = d15;
        {n.pad_e[3], n.pad_o[3]} = dpof;
        if (s.ctl_b[F_RING+:2] == SEL_GPIO) // see R4
        begin
            n.pad_e[2] = gpio_oe_in[2];
            n.pad_o[2] = gpio_o_in[2];
        end
        else
        begin
            n.pad_e[2] = 1'b0;
            n.pad_o[2] = 1'b0;
        end
        if (!s.ctl_b[F_SUP]) // see R7, R8
        begin
            n.pad_e[4] = 1'b1;
            n.pad_o[4] = n.supply_on;
        end
        else
        begin
            n.pad_e[4] = gpio_oe_in[4];
            n.pad_o[4] = gpio_o_in[4];
        end
        if (s.ctl_b[F_PAN+:2] == SEL_GPIO) // see R12
        begin
            n.pad_e[5] = gpio_oe_in[5];
            n.pad_o[5] = gpio_o_in[5];
        end
        else
        begin
            n.pad_e[5] = 1'b0; // see R9
            n.pad_o[5] = 1'b0;
        end

        // Inputs seen by the routed functions; idle high when not selected
        n.gpio_i[0] = (s.ctl_c[F_P14+:2] == SEL_GPIO) ? pad_in[0] : 1'b1;
        n.gpio_i[1] = (s.ctl_c[F_P15+:2] == SEL_GPIO) ? pad_in[1] : 1'b1;
        n.gpio_i[2] = (s.ctl_b[F_RING+:2] == SEL_GPIO) ? pad_in[2] : 1'b1;
        n.gpio_i[3] = (s.ctl_b[F_POF+:2] == SEL_GPIO) ? pad_in[3] : 1'b1;
        n.gpio_i[4] = s.ctl_b[F_SUP] ? pad_in[4] : 1'b1;
        n.gpio_i[5] = (s.ctl_b[F_PAN+:2] == SEL_GPIO) ? pad_in[5] : 1'b1;
        n.kbd16_i = (s.ctl_b[F_POF+:2] == SEL_ALT) ? pad_in[3] : 1'b1;
        n.ric_i = (EXTENDED && s.ctl_b[F_POF+:2] == SEL_EXT) ? pad_in[3] : 1'b1;
        n.dcd_i = (EXTENDED && s.ctl_b[F_PAN+:2] == SEL_EXT) ? pad_in[5] : 1'b1;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s <= '0;
            s.ctl_c <= RST_CTL;
            s.ctl_b <= RST_CTL;
            s.gcfg <= RST_GCFG;
            s.ring_q <= 1'b1;
            s.pan_q <= 1'b1;
            s.gpio_i <= 6'h3f;
            s.kbd16_i <= 1'b1;
            s.ric_i <= 1'b1;
            s.dcd_i <= 1'b1;
            s.aw_rdy <= 1'b1;
            s.w_rdy <= 1'b1;
            s.ar_rdy <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign s_axi_awready_out = s.aw_rdy;
    assign s_axi_wready_out = s.w_rdy;
    assign s_axi_bvalid_out = s.bvalid;
    assign s_axi_bresp_out = s.bresp;
    assign s_axi_arready_out = s.ar_rdy;
    assign s_axi_rvalid_out = s.rvalid;
    assign s_axi_rdata_out = s.rdata;
    assign s_axi_rresp_out = s.rresp;
    assign pad_out = s.pad_o;
    assign pad_oe_out = s.pad_e;
    assign gpio_i_out = s.gpio_i;
    assign kbd_port_line16_out = s.kbd16_i;
    assign uartc_ring_out = s.ric_i;
    assign uartc_carrier_out = s.dcd_i;
    assign supply_onoff_ctl_out = s.supply_on;
    assign clk_24m_sel_out = s.gcfg[F_CLK24];
    assign irq_out = s.irq;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence ring_edge;
        ring_fall;
    endsequence

    sequence panel_edge_on;
        pan_fall && !main_power_ok_in;
    endsequence

    sequence panel_edge_off;
        pan_fall && main_power_ok_in;
    endsequence

    a_p14_irq_route: assert property ( // see R1
        s.ctl_c[F_P14+:2] == SEL_BASE |=> pad_oe_out[0] && pad_out[0] == $past(irq14_in))
        else $error("pin 14 does not carry irq14");
    a_p15_wdt_route: assert property ( // see R2
        s.ctl_c[F_P15+:2] == SEL_ALT |=> pad_oe_out[1] && pad_out[1] == $past(watchdog_in))
        else $error("pin 15 does not carry watchdog");
    a_clk_sel_follow: assert property ( // see R3
        s.bvalid && !$past(s.bvalid) && $past(s.awaddr) == ADDR_GCFG && $past(s.wlane0)
        |-> clk_24m_sel_out == $past(s.wdata[F_CLK24]))
        else $error("clock select did not follow write");
    a_ring_gpio_route: assert property ( // see R4
        s.ctl_b[F_RING+:2] == SEL_GPIO |=> pad_oe_out[2] == $past(gpio_oe_in[2]))
        else $error("ring pin gpio enable wrong");
    a_ring_power_on: assert property ( // see R5
        ring_edge |=> supply_onoff_ctl_out && s.sts[EV_RING])
        else $error("ring pulse did not switch supply on");
    a_pof_irq_route: assert property ( // see R6
        s.ctl_b[F_POF+:2] == SEL_BASE |=> pad_oe_out[3] && pad_out[3] == irq_out)
        else $error("power-off pin does not carry interrupt");
    a_sup_pin_route: assert property ( // see R7
        !s.ctl_b[F_SUP] |=> pad_oe_out[4] && pad_out[4] == supply_onoff_ctl_out)
        else $error("supply pin does not carry supply control");
    a_supply_held: assert property ( // see R8
        !ring_fall && !pan_fall |=> supply_onoff_ctl_out == $past(supply_onoff_ctl_out))
        else $error("supply control changed without a request");
    a_panel_input: assert property ( // see R9
        s.ctl_b[F_PAN+:2] == SEL_BASE |=> !pad_oe_out[5])
        else $error("panel switch pin driven");
    a_panel_on_req: assert property ( // see R10
        panel_edge_on |=> supply_onoff_ctl_out && s.sts[EV_ON])
        else $error("panel switch did not request power on");
    a_panel_off_req: assert property ( // see R11
        panel_edge_off |=> !supply_onoff_ctl_out ##0 s.sts[EV_OFF])
        else $error("panel switch did not request power off");
    a_panel_gpio: assert property ( // see R12
        s.ctl_b[F_PAN+:2] == SEL_GPIO |=> pad_oe_out[5] == $past(gpio_oe_in[5]))
        else $error("panel pin gpio enable wrong");
    a_route_prompt: assert property ( // see R13
        $changed(s.ctl_c) && s.ctl_c[F_P14+:2] == SEL_ALT
        |=> pad_out[0] == $past(power_led_in))
        else $error("pin 14 route change late");

    // Less common codes and the sticky status
    a_p14_ir_route: assert property ( // see R1
        s.ctl_c[F_P14+:2] == SEL_EXT
        |=> pad_oe_out[0] == EXTENDED && pad_out[0] == $past(ir_module_sel1_in))
        else $error("pin 14 does not carry IR select 1");
    a_ring_gpio_in: assert property ( // see R4
        s.ctl_b[F_RING+:2] == SEL_GPIO |=> gpio_i_out[2] == $past(pad_in[2]))
        else $error("ring pin gpio input wrong");
    a_ring_sts_sticky: assert property ( // see R5
        s.sts[EV_RING] && !(s.aw_seen && s.w_seen && !s.bvalid && s.awaddr == ADDR_CLR
        && s.wlane0 && s.wdata[EV_RING]) |=> s.sts[EV_RING])
        else $error("ring status lost without a clear");
    a_pof_kbd_route: assert property ( // see R6
        s.ctl_b[F_POF+:2] == SEL_ALT
        |=> pad_oe_out[3] == $past(kbd_port_line16_oe_in)
        && kbd_port_line16_out == $past(pad_in[3]))
        else $error("power-off pin does not carry keyboard line 16");
    a_panel_dcd_route: assert property ( // see R12
        s.ctl_b[F_PAN+:2] == SEL_EXT
        |=> !pad_oe_out[5]
        && uartc_carrier_out == (EXTENDED ? $past(pad_in[5]) : 1'b1))
        else $error("panel pin does not carry carrier input");
endmodule

// ==== design/pfm_pkg.sv ====
// Constants and state type for the multi-purpose pin router and power control.
// Assumes a single 10 MHz system clock and an AXI4-Lite master on the register port.
// Operation
// R1: Pin 14 select: 00 irq14, 01 gpio1 line4, 10 power LED, 11 IR select 1.
// R2: Pin 15 select: 00 irq15, 01 gpio1 line5, 10 watchdog, 11 IR select 2.
// R3: Bit 5 of the global config register picks 24 MHz over 14.318 MHz clock.
// R4: Ring pin select: 00 phone ring input, 01 gpio2 line0 as keyboard reset.
// R5: A ring pulse on the selected ring input switches the supply control on; the code lets a panel off request in the same cycle win.
// R6: Power-off pin: 00 off interrupt, 01 gpio2 line1, 10 kbd line16, 11 ring C.
// R7: Supply pin: select bit 0 gives supply control, 1 gives gpio2 line2.
// R8: Supply control output tells the main supply whether to be on.
// R9: Panel pin select 00 makes it the panel on/off switch input.
// R10: Falling panel edge with main supply absent requests power on.
// R11: Falling panel edge with main supply present requests power off.
// R12: Panel pin select 01 gives gpio2 line3, 11 gives serial C carrier input.
// R13: A select change takes effect at once, from the current field values.
package pfm_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTL_C = 8'h00;
    localparam logic [7:0] ADDR_CTL_B = 8'h04;
    localparam logic [7:0] ADDR_GCFG = 8'h08;
    localparam logic [7:0] ADDR_STS = 8'h0c;
    localparam logic [7:0] ADDR_CLR = 8'h10;
    localparam logic [7:0] ADDR_EN = 8'h14;
    localparam logic [7:0] ADDR_PADS = 8'h18;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_GCFG = 8'h00;
    localparam int F_P14 = 0;
    localparam int F_P15 = 2;
    localparam int F_RING = 1;
    localparam int F_POF = 3;
    localparam int F_SUP = 5;
    localparam int F_PAN = 6;
    localparam int F_CLK24 = 5;
    localparam logic [1:0] SEL_BASE = 2'h0;
    localparam logic [1:0] SEL_GPIO = 2'h1;
    localparam logic [1:0] SEL_ALT = 2'h2;
    localparam logic [1:0] SEL_EXT = 2'h3;
    localparam int NEV = 3;
    localparam int EV_RING = 0;
    localparam int EV_ON = 1;
    localparam int EV_OFF = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] ctl_c;
        logic [7:0] ctl_b;
        logic [7:0] gcfg;
        logic [NEV-1:0] sts;
        logic [NEV-1:0] en;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic aw_seen;
        logic [ADDR_W-1:0] awaddr;
        logic w_seen;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ring_q;
        logic pan_q;
        logic supply_on;
        logic irq;
        logic [5:0] pad_o;
        logic [5:0] pad_e;
        logic [5:0] gpio_i;
        logic kbd16_i;
        logic ric_i;
        logic dcd_i;
    } pfm_state_t;
endpackage

// ==== test/pfm_far_side.sv ====
// Far-side model: resolves the pad wires and models the main power supply.
// Assumes the bench gives the levels that outside parts put on undriven pads.
`timescale 1ns/1ps
module pfm_far_side (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Device pads and supply control
    input wire logic [5:0] pad_drv_in,
    input wire logic [5:0] pad_oe_in,
    input wire logic supply_ctl_in,
    // Outside levels and results
    input wire logic [5:0] ext_lvl_in,
    output logic [5:0] pad_lvl_out,
    output logic main_power_ok_out
);
    logic main_ok_reg;

    // The device wins where it drives
    assign pad_lvl_out = (pad_drv_in & pad_oe_in) | (ext_lvl_in & ~pad_oe_in);
    assign main_power_ok_out = main_ok_reg;

    // Main supply follows the on/off control one cycle later
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            main_ok_reg <= 1'b0;
        else
            main_ok_reg <= supply_ctl_in;
    end
endmodule

// ==== test/tb_irq_apm_pin_function_mux.sv ====
// Bench for the pin router: AXI4-Lite tasks and directed pin and supply checks.
// Assumes the far-side model resolves pads and drives the main supply status.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_irq_apm_pin_function_mux;
    import pfm_pkg::*;
    logic clk_sys_in, sys_rst_in;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic irq14, irq15, led, wdog, irs1, irs2, kbd, kbd_oe, main_ok;
    logic [5:0] gpio_o, gpio_oe, ext, pad_in, pad_out, pad_oe, gpio_i;
    logic kbd_i, uring, ucar, sup, clk24, irq;
    logic [3:0] v;
    int n_mismatch = 0;
    int compares = 0;

    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    pfm_pin_router #(.EXTENDED(1'b1)) i_pfm_pin_router (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .irq14_in(irq14), .irq15_in(irq15), .power_led_in(led), .watchdog_in(wdog),
        .ir_module_sel1_in(irs1), .ir_module_sel2_in(irs2), .gpio_o_in(gpio_o),
        .gpio_oe_in(gpio_oe), .kbd_port_line16_in(kbd), .kbd_port_line16_oe_in(kbd_oe),
        .main_power_ok_in(main_ok), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe),
        .gpio_i_out(gpio_i), .kbd_port_line16_out(kbd_i), .uartc_ring_out(uring),
        .uartc_carrier_out(ucar), .supply_onoff_ctl_out(sup), .clk_24m_sel_out(clk24),
        .irq_out(irq));

    pfm_far_side i_pfm_far_side (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .pad_drv_in(pad_out),
        .pad_oe_in(pad_oe), .supply_ctl_in(sup), .ext_lvl_in(ext), .pad_lvl_out(pad_in),
        .main_power_ok_out(main_ok));

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ad, wd, ta, tw, b;
        logic [1:0] r;
        begin
            ad = 1'b0;
            wd = 1'b0;
            b = 1'b0;
            @(posedge clk_sys_in);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(ad && wd))
            begin
                @(negedge clk_sys_in);
                ta = awvalid & awready;
                tw = wvalid & wready;
                @(posedge clk_sys_in);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
                ad = ad | ta;
                wd = wd | tw;
            end
            while (!b)
            begin
                @(negedge clk_sys_in);
                b = bvalid;
                r = bresp;
                @(posedge clk_sys_in);
            end
            bready <= 1'b0;
            `CHK("bresp", er, r)
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic t, rv;
        logic [31:0] d;
        logic [1:0] r;
        begin
            t = 1'b0;
            rv = 1'b0;
            @(posedge clk_sys_in);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            while (!t)
            begin
                @(negedge clk_sys_in);
                t = arready;
                @(posedge clk_sys_in);
            end
            arvalid <= 1'b0;
            while (!rv)
            begin
                @(negedge clk_sys_in);
                rv = rvalid;
                d = rdata;
                r = rresp;
                @(posedge clk_sys_in);
            end
            rready <= 1'b0;
            `CHK("rdata", {24'h0, ed}, d)
            `CHK("rresp", er, r)
        end
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys_in);
        ext[i] <= 1'b0;
        wait_n(2);
        @(posedge clk_sys_in);
        ext[i] <= 1'b1;
        wait_n(1);
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #500000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, irq14, irq15, led, wdog} = '0;
        {irs1, irs2, kbd, kbd_oe, awaddr, araddr, wdata} = '0;
        gpio_o = 6'h00;
        gpio_oe = 6'h00;
        ext = 6'h3f;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        wait_n(1);
        `CHK("pad oe", 6'h1b, pad_oe)
        `CHK("gpio in", 6'h3f, gpio_i)
        `CHK("supply", 1'b0, sup)
        rd(ADDR_CTL_C, RST_CTL, RESP_OKAY);
        rd(ADDR_CTL_B, RST_CTL, RESP_OKAY);
        wr(ADDR_GCFG, 8'h20, RESP_OKAY);
        wait_n(1);
        `CHK("clk sel", 1'b1, clk24)
        rd(ADDR_GCFG, 8'h20, RESP_OKAY);
        wr(ADDR_GCFG, 8'h00, RESP_OKAY);
        wait_n(1);
        `CHK("clk sel", 1'b0, clk24)
        @(posedge clk_sys_in);
        gpio_oe <= 6'h3f;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CTL_C, 8'(c * 5), RESP_OKAY);
            for (int k = 0; k < 4; k++)
            begin
                @(posedge clk_sys_in);
                v = {~k[0], k[0] ^ k[1], k[1], k[0]};
                {irq14, irq15, led, wdog} <= {v[0], v[0], v[2], v[2]};
                {irs1, irs2, gpio_o[1:0]} <= {v[3], v[3], v[1], v[1]};
                wait_n(2);
                `CHK("pad14", v[c], pad_out[0])
                `CHK("pad15", v[c], pad_out[1])
                `CHK("oe1415", 2'h3, pad_oe[1:0])
            end
        end
        @(posedge clk_sys_in);
        gpio_oe <= 6'h1b;
        gpio_o <= 6'h00;
        kbd_oe <= 1'b1;
        wr(ADDR_EN, 8'h07, RESP_OKAY);
        pulse(2);
        `CHK("supply", 1'b1, sup)
        `CHK("pad4", 2'h3, {pad_oe[4], pad_out[4]})
        `CHK("irq", 1'b1, irq)
        rd(ADDR_STS, 8'h01, RESP_OKAY);
        wr(ADDR_CLR, 8'h01, RESP_OKAY);
        rd(ADDR_STS, 8'h00, RESP_OKAY);
        wait_n(0);
        `CHK("irq", 1'b0, irq)
        pulse(5);
        `CHK("supply", 1'b0, sup)
        pulse(5);
        `CHK("supply", 1'b1, sup)
        rd(ADDR_STS, 8'h06, RESP_OKAY);
        wr(ADDR_EN, 8'h00, RESP_OKAY);
        wait_n(1);
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_EN, 8'h07, RESP_OKAY);
        wait_n(1);
        `CHK("irq", 1'b1, irq)
        @(posedge clk_sys_in);
        ext[3] <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CTL_B, 8'(c << 3), RESP_OKAY);
            wait_n(3);
            `CHK("pof oe", c != 3, pad_oe[3])
            if (c < 3) `CHK("pof out", c == 0, pad_out[3])
            `CHK("kbd16 in", c != 2, kbd_i)
            `CHK("ring c", c != 3, uring)
        end
        wr(ADDR_CLR, 8'h07, RESP_OKAY);
        wr(ADDR_CTL_B, 8'h22, RESP_OKAY);
        @(posedge clk_sys_in);
        ext[2] <= 1'b0;
        wait_n(3);
        `CHK("gpio in", 6'h2b, gpio_i)
        `CHK("pad4 gpio", 1'b0, pad_out[4])
        @(posedge clk_sys_in);
        ext[2] <= 1'b1;
        rd(ADDR_STS, 8'h00, RESP_OKAY);
        wr(ADDR_CTL_B, 8'h40, RESP_OKAY);
        @(posedge clk_sys_in);
        ext[5] <= 1'b0;
        wait_n(3);
        `CHK("gpio in", 1'b0, gpio_i[5])
        `CHK("supply", 1'b1, sup)
        wr(ADDR_CTL_B, 8'hc0, RESP_OKAY);
        wait_n(3);
        `CHK("carrier", 2'h0, {pad_oe[5], ucar})
        rd(8'h1c, 8'h00, RESP_SLVERR);
        wr(8'h1c, 8'hff, RESP_SLVERR);
        test_done();
    end
endmodule
